// [ccb_pkg.sv]
//----------------------------------------------------------------
// Calibration tag bank constants
//----------------------------------------------------------------
`default_nettype none

package ccb_pkg;

	// Bus widths
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;

	// Register indexes; byte address is four times the index
	localparam logic [9:0] IDX_CH1_A = 10'h077;
	localparam logic [9:0] IDX_CH2_A = 10'h078;
	localparam logic [9:0] IDX_CRC_A = 10'h079;
	localparam logic [9:0] IDX_CH1_B = 10'h07A;
	localparam logic [9:0] IDX_CH2_B = 10'h07B;
	localparam logic [9:0] IDX_CRC_B = 10'h07C;
	localparam logic [9:0] IDX_CH1_C = 10'h07D;
	localparam logic [9:0] IDX_CH2_C = 10'h07E;
	localparam logic [9:0] IDX_CRC_C = 10'h07F;
	localparam logic [9:0] IDX_STATUS = 10'h080;
	localparam int NREG = 9;

	// Field layout
	localparam int SELECT_BIT = 7;
	localparam int TRIM_MSB = 5;
	localparam logic [7:0] MASK_CH1 = 8'hBF;
	localparam logic [7:0] MASK_CH2 = 8'h3F;
	localparam logic [7:0] MASK_CRC = 8'hFF;
	localparam logic [7:0] BANK_RESET = 8'h00;

	// Status register layout
	localparam int STAT_TAG_LSB = 0;
	localparam int STAT_ERR_BIT = 2;

	// Active tag codes
	typedef enum logic [1:0] {
		TAG_NONE = 2'b00,
		TAG_A = 2'b01,
		TAG_B = 2'b10,
		TAG_C = 2'b11
	} ccb_tag_t;

	// Checksum: CRC-8, MSB first over channel 1 byte then channel 2 byte
	localparam logic [7:0] CRC_POLY = 8'h07;
	localparam logic [7:0] CRC_INIT = 8'h00;

	// Gain in Q2.14: unity is 16384, one trim step 0.00488 is 80 LSB
	localparam logic [15:0] GAIN_ONE = 16'h4000;
	localparam logic [15:0] GAIN_STEP = 16'h0050;
	localparam logic [15:0] GAIN_MIN = 16'h3600;
	localparam logic [15:0] GAIN_MAX = 16'h49B0;

	// AXI responses
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

`default_nettype wire

// [ccb_tag_bank.sv]
// Behaviour
// [R1] The tag B checksum is used only while the tag B select bit is one.
// [R2] Software writes into the tag B checksum the CRC of the two tag B channel registers.
// [R3] Select bit 7 of channel 1 tag C enables tag C values when one and ignores them when zero.
// [R4] With tag C and tag B both selected, tag C values are applied and tag B values ignored.
// [R5] Each six-bit trim is a two's complement value from -32 to 31.
// [R6] The selected trim scales its channel current within about fifteen percent.
// [R7] Channel gain is one plus the signed trim times 0.00488.
// [R8] The tag C checksum is used only while the tag C select bit is one.
// [R9] Software writes into the tag C checksum the CRC of the two tag C channel registers.
// [R10] A set select bit makes the channel trims come from that tag.
// [R11] With tag B and tag A both selected, tag B values win over tag A.
// [R12] Software writes into the tag A checksum the CRC of the two tag A channel registers.
// [R13] With no tag selected both channels get unity gain.
// [R14] The stored checksum of the winning tag is checked and a mismatch refuses its values.
//
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none

module ccb_tag_bank
	import ccb_pkg::*;
(
	input wire logic clk_i, // 100 MHz clock
	input wire logic rst_i, // Sync reset, active high
	input wire logic [ccb_pkg::ADDR_W-1:0] s_axi_awaddr, // Write address
	input wire logic s_axi_awvalid, // Write address valid
	output logic s_axi_awready, // Write address ready
	input wire logic [ccb_pkg::DATA_W-1:0] s_axi_wdata, // Write data
	input wire logic [3:0] s_axi_wstrb, // Byte enables
	input wire logic s_axi_wvalid, // Write data valid
	output logic s_axi_wready, // Write data ready
	output logic [1:0] s_axi_bresp, // Write response
	output logic s_axi_bvalid, // Write response valid
	input wire logic s_axi_bready, // Write response ready
	input wire logic [ccb_pkg::ADDR_W-1:0] s_axi_araddr, // Read address
	input wire logic s_axi_arvalid, // Read address valid
	output logic s_axi_arready, // Read address ready
	output logic [ccb_pkg::DATA_W-1:0] s_axi_rdata, // Read data
	output logic [1:0] s_axi_rresp, // Read response
	output logic s_axi_rvalid, // Read data valid
	input wire logic s_axi_rready, // Read data ready
	output logic [15:0] chan1_gain_o, // Channel 1 gain, Q2.14
	output logic [15:0] chan2_gain_o, // Channel 2 gain, Q2.14
	output logic [1:0] active_tag_o, // Tag in use
	output logic crc_err_o // Winning tag failed its check
);
	import ccb_pkg::*;

	//------------------------------------------------------------
	// State
	//------------------------------------------------------------
	typedef struct packed {
		logic [NREG-1:0][7:0] bank;
		logic aw_hold;
		logic [9:0] aw_idx;
		logic aw_ok;
		logic w_hold;
		logic [7:0] w_byte;
		logic w_en;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [15:0] gain1;
		logic [15:0] gain2;
		ccb_tag_t tag;
		logic crc_err;
	} ccb_state_t;

	ccb_state_t s_ff;
	ccb_state_t nxt_s;

	//------------------------------------------------------------
	// Helpers
	//------------------------------------------------------------
	// Index lies on a bank register
	function automatic logic in_bank(input logic [9:0] idx);
		return (idx >= IDX_CH1_A) && (idx <= IDX_CRC_C);
	endfunction

	// Writable bits of a bank register
	function automatic logic [7:0] wmask(input logic [9:0] idx);
		logic [7:0] m;
		m = MASK_CRC;
		if (idx == IDX_CH1_A || idx == IDX_CH1_B || idx == IDX_CH1_C) begin
			m = MASK_CH1;
		end else if (idx == IDX_CH2_A || idx == IDX_CH2_B || idx == IDX_CH2_C) begin
			m = MASK_CH2;
		end
		return m;
	endfunction

	// CRC-8 over two bytes
	function automatic logic [7:0] crc_of(input logic [7:0] b1, input logic [7:0] b2);
		logic [7:0] c;
		logic [15:0] d;
		c = CRC_INIT;
		d = {b1, b2};
		for (int i = 15; i >= 0; i--) begin
			if (c[7] ^ d[i]) begin
				c = {c[6:0], 1'b0} ^ CRC_POLY;
			end else begin
				c = {c[6:0], 1'b0};
			end
		end
		return c;
	endfunction

	// Gain from a signed six-bit trim
	function automatic logic [15:0] gain_of(input logic [5:0] t);
		int v;
		v = int'(GAIN_ONE) + int'($signed(t)) * int'(GAIN_STEP); // see [R5] see [R7]
		return v[15:0];
	endfunction

	// Bank slot of an index
	function automatic int slot(input logic [9:0] idx);
		return int'(idx - IDX_CH1_A);
	endfunction

	//------------------------------------------------------------
	// Tag selection
	//------------------------------------------------------------
	logic sel_a;
	logic sel_b;
	logic sel_c;
	logic ok_a;
	logic ok_b;
	logic ok_c;
	logic [5:0] trim1;
	logic [5:0] trim2;
	logic win_ok;
	ccb_tag_t win_tag;

	// Priority C over B over A, checksum gates the winner
	always_comb begin
		sel_a = s_ff.bank[slot(IDX_CH1_A)][SELECT_BIT];
		sel_b = s_ff.bank[slot(IDX_CH1_B)][SELECT_BIT];
		sel_c = s_ff.bank[slot(IDX_CH1_C)][SELECT_BIT]; // see [R3]
		ok_a = crc_of(s_ff.bank[slot(IDX_CH1_A)], s_ff.bank[slot(IDX_CH2_A)]) == s_ff.bank[slot(IDX_CRC_A)];
		ok_b = crc_of(s_ff.bank[slot(IDX_CH1_B)], s_ff.bank[slot(IDX_CH2_B)]) == s_ff.bank[slot(IDX_CRC_B)];
		ok_c = crc_of(s_ff.bank[slot(IDX_CH1_C)], s_ff.bank[slot(IDX_CH2_C)]) == s_ff.bank[slot(IDX_CRC_C)];
		win_tag = TAG_NONE;
		win_ok = 1'b1;
		trim1 = 6'h00;
		trim2 = 6'h00;
		if (sel_c) begin // see [R4] see [R10]
			win_tag = TAG_C;
			win_ok = ok_c; // see [R8]
			trim1 = s_ff.bank[slot(IDX_CH1_C)][TRIM_MSB:0];
			trim2 = s_ff.bank[slot(IDX_CH2_C)][TRIM_MSB:0];
		end else if (sel_b) begin // see [R11]
			win_tag = TAG_B;
			win_ok = ok_b; // see [R1]
			trim1 = s_ff.bank[slot(IDX_CH1_B)][TRIM_MSB:0];
			trim2 = s_ff.bank[slot(IDX_CH2_B)][TRIM_MSB:0];
		end else if (sel_a) begin
			win_tag = TAG_A;
			win_ok = ok_a;
			trim1 = s_ff.bank[slot(IDX_CH1_A)][TRIM_MSB:0];
			trim2 = s_ff.bank[slot(IDX_CH2_A)][TRIM_MSB:0];
		end
		// A failing winner gives unity, never an older tag
		if (!win_ok) begin // see [R14]
			trim1 = 6'h00;
			trim2 = 6'h00;
		end
	end

	//------------------------------------------------------------
	// Next state
	//------------------------------------------------------------
	always_comb begin
		nxt_s = s_ff;
		// Write address channel
		if (s_ff.awready && s_axi_awvalid) begin
			nxt_s.aw_hold = 1'b1;
			nxt_s.aw_idx = s_axi_awaddr[11:2];
			nxt_s.aw_ok = (s_axi_awaddr[1:0] == 2'b00) && in_bank(s_axi_awaddr[11:2]);
		end
		// Write data channel
		if (s_ff.wready && s_axi_wvalid) begin
			nxt_s.w_hold = 1'b1;
			nxt_s.w_byte = s_axi_wdata[7:0];
			nxt_s.w_en = s_axi_wstrb[0];
		end
		// Commit once both halves are held
		if (s_ff.aw_hold && s_ff.w_hold) begin
			nxt_s.aw_hold = 1'b0;
			nxt_s.w_hold = 1'b0;
			nxt_s.bvalid = 1'b1;
			nxt_s.bresp = s_ff.aw_ok ? RESP_OKAY : RESP_SLVERR;
			if (s_ff.aw_ok && s_ff.w_en) begin
				nxt_s.bank[slot(s_ff.aw_idx)] = s_ff.w_byte & wmask(s_ff.aw_idx);
			end
		end
		if (s_ff.bvalid && s_axi_bready) begin
			nxt_s.bvalid = 1'b0;
		end
		nxt_s.awready = !nxt_s.aw_hold && !nxt_s.bvalid;
		nxt_s.wready = !nxt_s.w_hold && !nxt_s.bvalid;
		// Read channel
		if (s_ff.rvalid && s_axi_rready) begin
			nxt_s.rvalid = 1'b0;
		end
		if (s_ff.arready && s_axi_arvalid) begin
			nxt_s.rvalid = 1'b1;
			nxt_s.rdata = 32'h0000_0000;
			nxt_s.rresp = RESP_OKAY;
			if (s_axi_araddr[1:0] != 2'b00) begin
				nxt_s.rresp = RESP_SLVERR;
			end else if (in_bank(s_axi_araddr[11:2])) begin
				nxt_s.rdata[7:0] = s_ff.bank[slot(s_axi_araddr[11:2])];
			end else if (s_axi_araddr[11:2] == IDX_STATUS) begin
				nxt_s.rdata[STAT_TAG_LSB +: 2] = s_ff.tag;
				nxt_s.rdata[STAT_ERR_BIT] = s_ff.crc_err;
			end else begin
				nxt_s.rresp = RESP_SLVERR;
			end
		end
		nxt_s.arready = !nxt_s.rvalid;
		// Channel gains, unity when nothing usable
		nxt_s.gain1 = gain_of(trim1); // see [R6] see [R13]
		nxt_s.gain2 = gain_of(trim2);
		nxt_s.tag = win_ok ? win_tag : TAG_NONE;
		nxt_s.crc_err = !win_ok; // see [R14]
	end

	//------------------------------------------------------------
	// Registers
	//------------------------------------------------------------
	// Gains read zero in reset and unity from the first edge after it
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	// Outputs straight from flops
	assign s_axi_awready = s_ff.awready;
	assign s_axi_wready = s_ff.wready;
	assign s_axi_bvalid = s_ff.bvalid;
	assign s_axi_bresp = s_ff.bresp;
	assign s_axi_arready = s_ff.arready;
	assign s_axi_rvalid = s_ff.rvalid;
	assign s_axi_rdata = s_ff.rdata;
	assign s_axi_rresp = s_ff.rresp;
	assign chan1_gain_o = s_ff.gain1;
	assign chan2_gain_o = s_ff.gain2;
	assign active_tag_o = s_ff.tag;
	assign crc_err_o = s_ff.crc_err;

	//------------------------------------------------------------
	// Checks
	//------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// Stored trims of tags C and B, for the gain checks
	logic [5:0] trim1_c;
	logic [5:0] trim2_c;
	logic [5:0] trim1_b;
	assign trim1_c = s_ff.bank[slot(IDX_CH1_C)][TRIM_MSB:0];
	assign trim2_c = s_ff.bank[slot(IDX_CH2_C)][TRIM_MSB:0];
	assign trim1_b = s_ff.bank[slot(IDX_CH1_B)][TRIM_MSB:0];

	// Tag selection and priority
	chk_tag_c_wins: assert property (sel_c && ok_c |=> active_tag_o == TAG_C) // see [R3] see [R4]
		else $error("tag C selected and valid but not active");
	chk_tag_c_off: assert property (active_tag_o == TAG_C |-> $past(sel_c)) // see [R3]
		else $error("tag C active while its select was clear");
	chk_tag_b_wins: assert property (sel_b && !sel_c && ok_b |=> active_tag_o == TAG_B) // see [R11]
		else $error("tag B selected and valid but not active");
	chk_tag_b_use: assert property (active_tag_o == TAG_B |-> $past(sel_b && !sel_c && ok_b)) // see [R1]
		else $error("tag B active without select or valid checksum");
	chk_tag_a_use: assert property (sel_a && !sel_b && !sel_c && ok_a |=> active_tag_o == TAG_A) // see [R10]
		else $error("tag A selected alone and valid but not active");
	chk_tag_a_prio: assert property (active_tag_o == TAG_A |-> $past(sel_a && !sel_b && !sel_c)) // see [R11]
		else $error("tag A active while a newer tag was selected");
	chk_tag_none_idle: assert property (active_tag_o == TAG_NONE && !crc_err_o |-> // see [R13]
		$past(!sel_a && !sel_b && !sel_c))
		else $error("no tag active although one was selected");
	chk_none_unity: assert property (!sel_a && !sel_b && !sel_c |=> // see [R13]
		chan1_gain_o == GAIN_ONE && chan2_gain_o == GAIN_ONE)
		else $error("no tag selected but gain not unity");

	// Checksum gating
	chk_crc_refuse: assert property (crc_err_o |-> // see [R14]
		chan1_gain_o == GAIN_ONE && chan2_gain_o == GAIN_ONE && active_tag_o == TAG_NONE)
		else $error("checksum mismatch but trims applied");
	chk_crc_c_used: assert property (sel_c && !ok_c |=> crc_err_o) // see [R8]
		else $error("bad tag C checksum not flagged");
	chk_crc_b_used: assert property (sel_b && !sel_c && !ok_b |=> crc_err_o) // see [R1]
		else $error("bad tag B checksum not flagged");
	chk_crc_b_ignored: assert property (sel_c && ok_c |=> !crc_err_o) // see [R4]
		else $error("checksum error raised while a valid tag C wins");

	// Gain values, unity plus signed trim steps
	chk_gain_range: assert property (!$past(rst_i) |-> // see [R6]
		chan1_gain_o >= GAIN_MIN && chan1_gain_o <= GAIN_MAX &&
		chan2_gain_o >= GAIN_MIN && chan2_gain_o <= GAIN_MAX)
		else $error("gain outside trim range");
	chk_gain_source: assert property (active_tag_o == TAG_C |-> // see [R7] see [R10]
		int'(chan1_gain_o) == int'(GAIN_ONE) +
		int'(GAIN_STEP) * int'($signed($past(trim1_c))))
		else $error("channel 1 gain not taken from tag C");
	chk_gain2_source: assert property (active_tag_o == TAG_C |-> // see [R7]
		int'(chan2_gain_o) == int'(GAIN_ONE) +
		int'(GAIN_STEP) * int'($signed($past(trim2_c))))
		else $error("channel 2 gain not taken from tag C");
	chk_gain_b_source: assert property (active_tag_o == TAG_B |-> // see [R10]
		int'(chan1_gain_o) == int'(GAIN_ONE) +
		int'(GAIN_STEP) * int'($signed($past(trim1_b))))
		else $error("channel 1 gain not taken from tag B");
	chk_trim_sign: assert property (active_tag_o == TAG_C && $past(trim1_c[TRIM_MSB]) |-> chan1_gain_o < GAIN_ONE) // see [R5]
		else $error("negative trim did not lower the gain");

	// Register bus handshakes
	chk_write_resp: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |->
		##2 s_axi_bvalid)
		else $error("write response late");
	chk_read_lat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data not offered one cycle after the address");
	chk_aw_taken: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
		else $error("write address ready stayed high after a transfer");
	chk_w_taken: assert property (s_axi_wvalid && s_axi_wready |=> !s_axi_wready)
		else $error("write data ready stayed high after a transfer");
	chk_ready_gate: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write ready high while a response is pending");
	chk_arready_gate: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address ready high while read data is pending");
	chk_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
		else $error("upper read data bits not zero");

	// Main scenarios
	cov_tag_c: cover property (active_tag_o == TAG_C && !crc_err_o);
	cov_crc_bad: cover property (crc_err_o);
	cov_read_status: cover property (s_axi_arvalid && s_axi_arready && s_axi_araddr[11:2] == IDX_STATUS);
	cov_tag_b_over_a: cover property (active_tag_o == TAG_B && $past(sel_a));
	cov_no_tag: cover property (!sel_a && !sel_b && !sel_c && $past(sel_a));

endmodule

`default_nettype wire

// [ccb_tag_bank_tb.sv]
`timescale 1ns/1ps
`default_nettype none

module ccb_tag_bank_tb;
	import ccb_pkg::*;

	//------------------------------------------------
	// Signals and bookkeeping
	//------------------------------------------------
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [11:0] s_axi_awaddr = 12'h000;
	logic [11:0] s_axi_araddr = 12'h000;
	logic [31:0] s_axi_wdata = 32'h00000000;
	logic [3:0] s_axi_wstrb = 4'h0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, crc_err;
	logic [1:0] s_axi_bresp, s_axi_rresp, active_tag;
	logic [31:0] s_axi_rdata;
	logic [15:0] chan1_gain, chan2_gain;
	int n_fail = 0;
	int samples_checked = 0;
	int cycles = 0;
	logic [1:0] bq[$];
	logic [33:0] rq[$];
	logic [5:0] tr1 [3];
	logic [5:0] tr2 [3];
	logic sel [3] = '{1'b0, 1'b0, 1'b0};
	logic good [3] = '{1'b1, 1'b1, 1'b1};
	logic [5:0] t1_pick, t2_pick;

	ccb_tag_bank i_dut (.clk_i(clk_i), .rst_i(rst_i), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.chan1_gain_o(chan1_gain), .chan2_gain_o(chan2_gain), .active_tag_o(active_tag), .crc_err_o(crc_err));

	// Free running clock
	always #5 clk_i = ~clk_i;

	//------------------------------------------------
	// Helpers
	//------------------------------------------------
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic print_verdict;
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// CRC-8, poly 07, MSB first over both channel bytes
	function automatic logic [7:0] crc8(input logic [7:0] a, input logic [7:0] b);
		logic [7:0] c;
		logic [15:0] d;
		c = 8'h00;
		d = {a, b};
		for (int i = 15; i >= 0; i--) begin
			c = (c[7] ^ d[i]) ? ((c << 1) ^ 8'h07) : (c << 1);
		end
		return c;
	endfunction

	function automatic logic [15:0] gain(input logic [5:0] t);
		return 16'(32'sh4000 + 32'sh50 * $signed(t));
	endfunction

	// AXI write, expected response noted for the monitor
	task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [3:0] s, input logic [1:0] exp);
		bq.push_back(exp);
		@(posedge clk_i);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h000000, d};
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clk_i);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
	endtask

	// AXI read, expected response and data noted for the monitor
	task automatic rd(input logic [11:0] a, input logic [1:0] exp, input logic [7:0] d);
		rq.push_back({exp, 24'h000000, d});
		@(posedge clk_i);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clk_i);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
	endtask

	// Expected outputs from the bench's own copy of the tags
	task automatic outs;
		logic [1:0] t;
		logic [15:0] g1, g2;
		logic e;
		t = sel[2] ? 2'h3 : sel[1] ? 2'h2 : sel[0] ? 2'h1 : 2'h0;
		g1 = 16'h4000;
		g2 = 16'h4000;
		e = 1'b0;
		if (t != 2'h0) begin
			if (good[t - 2'h1]) begin
				g1 = gain(tr1[t - 2'h1]);
				g2 = gain(tr2[t - 2'h1]);
			end else begin
				t = 2'h0;
				e = 1'b1;
			end
		end
		@(posedge clk_i);
		check({29'h0, active_tag, crc_err, chan1_gain, chan2_gain}, {29'h0, t, e, g1, g2});
	endtask

	// Program one tag: k 0..2 for A..C, bad flips checksum bits
	task automatic load(input int k, input logic s, input logic [5:0] a, input logic [5:0] b, input logic [7:0] bad);
		logic [11:0] base;
		logic [7:0] c1;
		base = {IDX_CH1_A, 2'b00} + 12'(12 * k);
		c1 = {s, 1'b0, a};
		wr(base, c1, 4'hF, RESP_OKAY);
		wr(base + 12'h004, {2'b00, b}, 4'hF, RESP_OKAY);
		wr(base + 12'h008, crc8(c1, {2'b00, b}) ^ bad, 4'hF, RESP_OKAY);
		sel[k] = s;
		tr1[k] = a;
		tr2[k] = b;
		good[k] = (bad == 8'h00);
		outs();
	endtask

	//------------------------------------------------
	// Monitor, timeout and main sequence
	//------------------------------------------------
	// Compare each bus answer with the oldest note
	always @(posedge clk_i) begin
		if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1) begin
			check({62'h0, s_axi_bresp}, {62'h0, bq.pop_front()});
		end
		if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
			check({30'h0, s_axi_rresp, s_axi_rdata}, {30'h0, rq.pop_front()});
		end
	end

	// Hang guard
	always @(posedge clk_i) begin
		cycles++;
		if (cycles > 20000) begin
			n_fail++;
			print_verdict();
		end
	end

	initial begin
		void'($urandom(32'hB5C7));
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		outs();
		// Reset values, masks and byte lane 0 strobe
		for (int i = 0; i < 9; i++) begin
			rd({IDX_CH1_A + 10'(i), 2'b00}, RESP_OKAY, 8'h00);
			wr({IDX_CH1_A + 10'(i), 2'b00}, 8'hFF, 4'hF, RESP_OKAY);
			rd({IDX_CH1_A + 10'(i), 2'b00}, RESP_OKAY, (i % 3 == 0) ? MASK_CH1 : (i % 3 == 1) ? MASK_CH2 : MASK_CRC);
			wr({IDX_CH1_A + 10'(i), 2'b00}, 8'h00, 4'h0, RESP_OKAY);
			rd({IDX_CH1_A + 10'(i), 2'b00}, RESP_OKAY, (i % 3 == 0) ? MASK_CH1 : (i % 3 == 1) ? MASK_CH2 : MASK_CRC);
			wr({IDX_CH1_A + 10'(i), 2'b00}, 8'h00, 4'hF, RESP_OKAY);
		end
		// Refused places
		wr({IDX_STATUS, 2'b00}, 8'h07, 4'hF, RESP_SLVERR);
		wr(12'h204, 8'h11, 4'hF, RESP_SLVERR);
		wr(12'h1F5, 8'h22, 4'hF, RESP_SLVERR);
		rd(12'h1F6, RESP_SLVERR, 8'h00);
		rd(12'h204, RESP_SLVERR, 8'h00);
		// Tag selection and priority
		load(0, 1'b1, 6'($urandom), 6'($urandom), 8'h00);
		load(1, 1'b0, 6'($urandom), 6'($urandom), 8'h33);
		load(1, 1'b1, 6'($urandom), 6'($urandom), 8'h00);
		// Trim extremes on both channels first, then random trims
		for (int j = 0; j < 4; j++) begin
			t1_pick = (j == 0) ? 6'h20 : (j == 1) ? 6'h1F : 6'($urandom);
			t2_pick = (j == 0) ? 6'h1F : (j == 1) ? 6'h20 : 6'($urandom);
			load(2, 1'b1, t1_pick, t2_pick, 8'h00);
		end
		// Tag B checksum does not matter while tag C wins
		load(1, 1'b1, 6'($urandom), 6'($urandom), 8'h44);
		load(1, 1'b1, 6'($urandom), 6'($urandom), 8'h00);
		load(2, 1'b1, 6'($urandom), 6'($urandom), 8'h01 << ($urandom % 8));
		rd({IDX_STATUS, 2'b00}, RESP_OKAY, 8'h04);
		load(2, 1'b0, 6'($urandom), 6'($urandom), 8'h11);
		rd({IDX_STATUS, 2'b00}, RESP_OKAY, 8'h02);
		// Back to tag A alone, then to no tag at all
		load(1, 1'b0, 6'($urandom), 6'($urandom), 8'h00);
		load(0, 1'b0, 6'($urandom), 6'($urandom), 8'h00);
		rd({IDX_STATUS, 2'b00}, RESP_OKAY, 8'h00);
		print_verdict();
	end

endmodule

`default_nettype wire
